// *** design/wl_defines.svh ***
`ifndef WL_DEFINES_SVH
`define WL_DEFINES_SVH

// ----------------------------------------------------------------
// Link shape
// ----------------------------------------------------------------
`define WL_LANES            2
`define WL_LANE_W           8
`define WL_DQ_W             16
`define WL_ADDR_W           14

// ----------------------------------------------------------------
// Mode register one layout
// ----------------------------------------------------------------
`define WL_MR1_BA           3'h1
`define WL_BIT_LEVEL        7
`define WL_BIT_OUT_DIS      12
`define WL_BIT_RTT2         9
`define WL_BIT_RTT1         6
`define WL_BIT_RTT0         2
`define WL_RTT_RZQ4         3'h1
`define WL_RTT_RZQ2         3'h2
`define WL_RTT_RZQ6         3'h3

// ----------------------------------------------------------------
// Timing, times in their own unit, counts derived
// ----------------------------------------------------------------
`define WL_MCLK_NS          10
`define WL_CK_DIV           8
`define WL_MODE_UPDATE_NCK  12
`define WL_MODE_UPDATE_CYC  (`WL_MODE_UPDATE_NCK * `WL_CK_DIV)
`define WL_MODE_CYCLE_NCK   4
`define WL_MODE_CYCLE_CYC   (`WL_MODE_CYCLE_NCK * `WL_CK_DIV)
`define WL_STROBE_EN_NCK    25
`define WL_STROBE_EN_CYC    (`WL_STROBE_EN_NCK * `WL_CK_DIV)
`define WL_STROBE_LOW_NCK   1
`define WL_FIRST_EDGE_NCK   40
`define WL_DQS_LOW_CYC      \
	((`WL_STROBE_LOW_NCK + `WL_FIRST_EDGE_NCK) * `WL_CK_DIV)
`define WL_ODT_OFF_NCK      8
`define WL_ODT_OFF_CYC      (`WL_ODT_OFF_NCK * `WL_CK_DIV)
`define WL_FB_DELAY_NS      9
`define WL_FB_DELAY_CYC     \
	(((`WL_FB_DELAY_NS) / (`WL_MCLK_NS)) < 1 ? 1 : \
	((`WL_FB_DELAY_NS) / (`WL_MCLK_NS)))
`define WL_FB_WAIT_CYC      16
`define WL_DQS_HIGH_CYC     4
`define WL_MAX_TRIES        16

// ----------------------------------------------------------------
// Controller register map
// ----------------------------------------------------------------
`define WL_REG_CTRL         4'h0
`define WL_REG_STATUS       4'h4
`define WL_REG_DELAY        4'h8
`define WL_CTRL_GO          0
`define WL_CTRL_RTT_LSB     1
`define WL_CTRL_RANK        4
`define WL_ST_BUSY          0
`define WL_ST_DONE          1
`define WL_ST_ERR           2
`define WL_ST_LOCK_LSB      3
`define WL_DLY_L1_LSB       8

`endif

// *** design/wl_pkg.sv ***
package wl_pkg;
`include "wl_defines.svh"

	typedef enum logic [3:0] {
		CS_IDLE     = 4'h0,
		CS_OTHER    = 4'h1,
		CS_WAIT_MRD = 4'h2,
		CS_ENTER    = 4'h3,
		CS_WAIT_MOD = 4'h4,
		CS_WAIT_EN  = 4'h5,
		CS_DQS_LOW  = 4'h6,
		CS_PULSE    = 4'h7,
		CS_FB_WAIT  = 4'h8,
		CS_EVAL     = 4'h9,
		CS_STOP     = 4'ha,
		CS_WAIT_ODT = 4'hb,
		CS_EXIT     = 4'hc,
		CS_WAIT_END = 4'hd
	} ctl_state_e;

	typedef struct packed {
		ctl_state_e                         state;
		logic [9:0]                         timer;
		logic [2:0]                         cnt;
		logic [3:0]                         pcnt;
		logic                               ck;
		logic [1:0]                         cs_n;
		logic                               ras_n;
		logic                               cas_n;
		logic                               we_n;
		logic [2:0]                         ba;
		logic [`WL_ADDR_W-1:0]              addr;
		logic                               odt;
		logic [`WL_LANES-1:0]               dqs;
		logic [`WL_LANES-1:0]               dqs_oe;
		logic [`WL_LANES-1:0][2:0]          tap;
		logic [`WL_LANES-1:0]               locked;
		logic [`WL_LANES-1:0]               saw0;
		logic [4:0]                         tries;
		logic                               busy;
		logic                               done;
		logic                               err;
		logic [2:0]                         rtt;
		logic                               rank;
		logic [`WL_LANES-1:0]               fb_s1;
		logic [`WL_LANES-1:0]               fb_s2;
		logic                               ack;
		logic [31:0]                        rdata;
	} ctl_s;

	typedef struct packed {
		logic                               ck;
		logic                               cs_n;
		logic                               ras_n;
		logic                               cas_n;
		logic                               we_n;
		logic [2:0]                         ba;
		logic [`WL_ADDR_W-1:0]              addr;
		logic                               odt;
		logic [`WL_LANES-1:0]               dqs;
		logic [`WL_LANES-1:0]               dqs_oe;
	} link_in_s;

	typedef struct packed {
		link_in_s                           s1;
		link_in_s                           s2;
		link_in_s                           s3;
		logic                               level;
		logic                               out_dis;
		logic [2:0]                         rtt;
		logic                               undef;
		logic                               exit_pend;
		logic [3:0]                         upd_cnt;
		logic [`WL_LANES-1:0]               fb;
		logic [`WL_LANES-1:0]               pend;
		logic [`WL_LANES-1:0][3:0]          fbc;
	} dev_s;

endpackage

// *** design/wl_if.sv ***
`timescale 1ns/1ps
`include "wl_defines.svh"

interface wl_if;
	logic                    ck_t;
	logic                    ck_c;
	logic [1:0]              cs_n;
	logic                    ras_n;
	logic                    cas_n;
	logic                    we_n;
	logic [2:0]              ba;
	logic [`WL_ADDR_W-1:0]   addr;
	logic                    odt;
	logic [`WL_LANES-1:0]    ctl_dqs_o;
	logic [`WL_LANES-1:0]    ctl_dqs_oe;
	logic [`WL_DQ_W-1:0]     ctl_dq_o;
	logic [`WL_DQ_W-1:0]     ctl_dq_oe;
	logic [`WL_LANES-1:0]    dev_dqs_o;
	logic [`WL_LANES-1:0]    dev_dqs_oe;
	logic [`WL_DQ_W-1:0]     dev_dq_o;
	logic [`WL_DQ_W-1:0]     dev_dq_oe;
	logic [`WL_LANES-1:0]    dqs_t;
	logic [`WL_LANES-1:0]    dqs_c;
	logic [`WL_DQ_W-1:0]     dq;

	// ----------------------------------------------------------------
	// Wire levels; an undriven wire rests low through termination
	// ----------------------------------------------------------------
	assign dqs_t = (ctl_dqs_oe & ctl_dqs_o) | (dev_dqs_oe & dev_dqs_o);
	assign dqs_c = (ctl_dqs_oe & ~ctl_dqs_o) | (dev_dqs_oe & ~dev_dqs_o);
	assign dq    = (ctl_dq_oe & ctl_dq_o) | (dev_dq_oe & dev_dq_o);

	modport ctl (
		output ck_t, ck_c, cs_n, ras_n, cas_n, we_n, ba, addr, odt,
		output ctl_dqs_o, ctl_dqs_oe, ctl_dq_o, ctl_dq_oe,
		input  dqs_t, dqs_c, dq
	);

	modport dev (
		input  ck_t, ck_c, cs_n, ras_n, cas_n, we_n, ba, addr, odt,
		input  ctl_dqs_oe, dqs_t, dqs_c, dq,
		output dev_dqs_o, dev_dqs_oe, dev_dq_o, dev_dq_oe
	);
endinterface

// *** design/wl_dram.sv ***
`timescale 1ns/1ps
`include "wl_defines.svh"

module wl_dram #(
	parameter bit RANK = 1'b0
) (
	input  wire logic   mclk,
	input  wire logic   reset_n,
	wl_if.dev           wl,
	output logic        leveling_active,
	output logic        dq_undefined,
	output logic        dqs_term_on,
	output logic        dq_term_on
);
	wl_pkg::dev_s r;
	wl_pkg::dev_s n;
	logic         ck_rise;
	logic         mrs;
	logic         strobe_end;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		n = r;
		n.s1.ck     = wl.ck_t;
		n.s1.cs_n   = wl.cs_n[RANK];
		n.s1.ras_n  = wl.ras_n;
		n.s1.cas_n  = wl.cas_n;
		n.s1.we_n   = wl.we_n;
		n.s1.ba     = wl.ba;
		n.s1.addr   = wl.addr;
		n.s1.odt    = wl.odt;
		n.s1.dqs    = wl.dqs_t;
		n.s1.dqs_oe = wl.ctl_dqs_oe;
		n.s2 = r.s1;
		n.s3 = r.s2;
		// Commands are taken on the rising link clock edge only
		ck_rise = r.s2.ck & ~r.s3.ck;
		mrs = ck_rise & ~r.s2.cs_n & ~r.s2.ras_n & ~r.s2.cas_n &
			~r.s2.we_n & (r.s2.ba == `WL_MR1_BA);
		strobe_end = r.level & (r.s3.dqs_oe != 2'h0) &
			(r.s2.dqs_oe == 2'h0);
		if (mrs) begin
			n.out_dis = r.s2.addr[`WL_BIT_OUT_DIS];
			n.rtt = {r.s2.addr[`WL_BIT_RTT2], r.s2.addr[`WL_BIT_RTT1],
				r.s2.addr[`WL_BIT_RTT0]};
			if (r.s2.addr[`WL_BIT_LEVEL]) begin
				n.level     = 1'b1;
				n.exit_pend = 1'b0;
				if (!r.level)
					n.undef = 1'b1;
			end else if (r.level) begin
				// Stay driving until the update delay has run out
				n.exit_pend = 1'b1;
				n.upd_cnt   = 4'(`WL_MODE_UPDATE_NCK);
			end
		end else if (r.exit_pend && ck_rise) begin
			n.upd_cnt = r.upd_cnt - 4'h1;
			if (r.upd_cnt == 4'h1) begin
				n.level     = 1'b0;
				n.undef     = 1'b0;
				n.exit_pend = 1'b0;
			end
		end
		if (strobe_end)
			n.undef = 1'b1;
		for (int l = 0; l < `WL_LANES; l++) begin
			if (r.fbc[l] != 4'h0) begin
				n.fbc[l] = r.fbc[l] - 4'h1;
				if (r.fbc[l] == 4'h1) begin
					n.fb[l] = r.pend[l];
					if (!r.exit_pend && r.s2.dqs_oe != 2'h0)
						n.undef = 1'b0;
				end
			end
			if (r.level && r.s2.dqs_oe[l] && r.s2.dqs[l] &&
				!r.s3.dqs[l]) begin
				// Clock high at the strobe edge reports one
				n.pend[l] = r.s2.ck;
				n.fbc[l]  = 4'(`WL_FB_DELAY_CYC);
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	// ----------------------------------------------------------------
	// Pins and status
	// ----------------------------------------------------------------
	// Feedback rides on bare data bits, the strobe stays undriven
	assign wl.dev_dqs_o  = '0;
	assign wl.dev_dqs_oe = '0;
	assign wl.dev_dq_o   = {{`WL_LANE_W{r.fb[1]}},
		{`WL_LANE_W{r.fb[0]}}};
	assign wl.dev_dq_oe  = {`WL_DQ_W{r.level & ~r.out_dis}};
	assign leveling_active = r.level;
	assign dq_undefined    = r.undef;
	// In leveling only the strobe pair follows the termination pin
	assign dqs_term_on = r.s2.odt & (r.level | (r.rtt != 3'h0));
	assign dq_term_on  = r.s2.odt & ~r.level & (r.rtt != 3'h0);
endmodule // wl_dram

// *** design/wl_ctrl.sv ***
`timescale 1ns/1ps
`include "wl_defines.svh"


module wl_ctrl (
	input  wire logic          mclk,
	input  wire logic          reset_n,
	input  wire logic [3:0]    address,
	input  wire logic          read,
	input  wire logic          write,
	input  wire logic [31:0]   writedata,
	output logic [31:0]        readdata,
	output logic               waitrequest,
	output logic               dq_term_on,
	wl_if.ctl                  wl
);
	wl_pkg::ctl_s r;
	wl_pkg::ctl_s n;
	logic                      req;
	logic                      cmd_edge;
	logic                      mrs_go;
	logic                      mrs_rank;
	logic [`WL_ADDR_W-1:0]     mrs_addr;
	logic                      rtt_ok;
	logic                      fb;
	logic [`WL_LANES-1:0]      lock_n;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		n        = r;
		mrs_go   = 1'b0;
		mrs_rank = r.rank;
		mrs_addr = '0;
		fb       = 1'b0;
		lock_n   = r.locked;
		req      = read | write;
		cmd_edge = (r.cnt == 3'(`WL_CK_DIV - 1));
		// Link clock from a divider; commands change on its fall
		n.cnt = r.cnt + 3'h1;
		n.ck  = (n.cnt >= 3'(`WL_CK_DIV / 2));
		if (r.timer != 10'h0)
			n.timer = r.timer - 10'h1;
		if (cmd_edge) begin
			n.cs_n  = 2'h3;
			n.ras_n = 1'b1;
			n.cas_n = 1'b1;
			n.we_n  = 1'b1;
		end
		n.fb_s1 = {wl.dq[`WL_LANE_W], wl.dq[0]};
		n.fb_s2 = r.fb_s1;
		// Judge the code being written, not the one held from before
		rtt_ok = (writedata[`WL_CTRL_RTT_LSB +: 3] == `WL_RTT_RZQ4) |
			(writedata[`WL_CTRL_RTT_LSB +: 3] == `WL_RTT_RZQ2) |
			(writedata[`WL_CTRL_RTT_LSB +: 3] == `WL_RTT_RZQ6);

		// ------------------------------------------------------------
		// Register slave, one wait cycle per access
		// ------------------------------------------------------------
		n.ack = req & ~r.ack;
		if (req && !r.ack) begin
			n.rdata = 32'h0;
			unique case (address)
				`WL_REG_CTRL: begin
					n.rdata[`WL_CTRL_RTT_LSB +: 3] = r.rtt;
					n.rdata[`WL_CTRL_RANK]         = r.rank;
				end
				`WL_REG_STATUS: begin
					n.rdata[`WL_ST_BUSY]              = r.busy;
					n.rdata[`WL_ST_DONE]              = r.done;
					n.rdata[`WL_ST_ERR]               = r.err;
					n.rdata[`WL_ST_LOCK_LSB +: 2]     = r.locked;
				end
				`WL_REG_DELAY: begin
					n.rdata[2:0]                      = r.tap[0];
					n.rdata[`WL_DLY_L1_LSB +: 3]      = r.tap[1];
				end
				default: n.rdata = 32'h0;
			endcase
		end

		// ------------------------------------------------------------
		// Leveling sequence
		// ------------------------------------------------------------
		unique case (r.state)
			wl_pkg::CS_IDLE: begin
				if (write && r.ack && address == `WL_REG_CTRL) begin
					n.rtt  = writedata[`WL_CTRL_RTT_LSB +: 3];
					n.rank = writedata[`WL_CTRL_RANK];
					if (writedata[`WL_CTRL_GO]) begin
						n.done = 1'b0;
						n.err  = 1'b0;
						if (!rtt_ok) begin
							// Illegal termination refused at start
							n.err = 1'b1;
						end else begin
							n.busy   = 1'b1;
							n.tap    = '0;
							n.locked = '0;
							n.saw0   = '0;
							n.tries  = 5'h0;
							n.state  = wl_pkg::CS_OTHER;
						end
					end
				end
			end
			wl_pkg::CS_OTHER: begin
				if (cmd_edge) begin
					mrs_go   = 1'b1;
					mrs_rank = ~r.rank;
					mrs_addr[`WL_BIT_OUT_DIS] = 1'b1;
					n.timer  = 10'(`WL_MODE_CYCLE_CYC);
					n.state  = wl_pkg::CS_WAIT_MRD;
				end
			end
			wl_pkg::CS_WAIT_MRD: begin
				if (r.timer == 10'h0)
					n.state = wl_pkg::CS_ENTER;
			end
			wl_pkg::CS_ENTER: begin
				if (cmd_edge) begin
					mrs_go = 1'b1;
					mrs_addr[`WL_BIT_LEVEL] = 1'b1;
					mrs_addr[`WL_BIT_RTT2]  = r.rtt[2];
					mrs_addr[`WL_BIT_RTT1]  = r.rtt[1];
					mrs_addr[`WL_BIT_RTT0]  = r.rtt[0];
					n.timer = 10'(`WL_MODE_UPDATE_CYC);
					n.state = wl_pkg::CS_WAIT_MOD;
				end
			end
			wl_pkg::CS_WAIT_MOD: begin
				if (r.timer == 10'h0) begin
					n.odt   = 1'b1;
					n.timer = 10'(`WL_STROBE_EN_CYC);
					n.state = wl_pkg::CS_WAIT_EN;
				end
			end
			wl_pkg::CS_WAIT_EN: begin
				if (r.timer == 10'h0) begin
					n.dqs    = '0;
					n.dqs_oe = '1;
					n.timer  = 10'(`WL_DQS_LOW_CYC);
					n.state  = wl_pkg::CS_DQS_LOW;
				end
			end
			wl_pkg::CS_DQS_LOW: begin
				// Pulses start on a clock fall so taps map to phase
				if (r.timer == 10'h0 && cmd_edge) begin
					n.pcnt  = 4'h0;
					n.state = wl_pkg::CS_PULSE;
				end
			end
			wl_pkg::CS_PULSE: begin
				n.pcnt = r.pcnt + 4'h1;
				if (r.pcnt == 4'hf) begin
					n.timer = 10'(`WL_FB_WAIT_CYC);
					n.state = wl_pkg::CS_FB_WAIT;
				end
			end
			wl_pkg::CS_FB_WAIT: begin
				if (r.timer == 10'h0)
					n.state = wl_pkg::CS_EVAL;
			end
			wl_pkg::CS_EVAL: begin
				for (int l = 0; l < `WL_LANES; l++) begin
					fb = r.fb_s2[l];
					if (!r.locked[l]) begin
						if (fb && r.saw0[l]) begin
							lock_n[l] = 1'b1;
						end else begin
							n.saw0[l] = ~fb;
							n.tap[l]  = r.tap[l] + 3'h1;
						end
					end
				end
				n.locked = lock_n;
				n.tries  = r.tries + 5'h1;
				n.timer  = 10'h0;
				if (lock_n == '1) begin
					n.state = wl_pkg::CS_STOP;
				end else if (r.tries == 5'(`WL_MAX_TRIES - 1)) begin
					// No transition seen within the try budget
					n.err   = 1'b1;
					n.state = wl_pkg::CS_STOP;
				end else begin
					n.state = wl_pkg::CS_DQS_LOW;
				end
			end
			wl_pkg::CS_STOP: begin
				n.dqs_oe = '0;
				n.odt    = 1'b0;
				n.timer  = 10'(`WL_ODT_OFF_CYC);
				n.state  = wl_pkg::CS_WAIT_ODT;
			end
			wl_pkg::CS_WAIT_ODT: begin
				if (r.timer == 10'h0)
					n.state = wl_pkg::CS_EXIT;
			end
			wl_pkg::CS_EXIT: begin
				if (cmd_edge) begin
					mrs_go = 1'b1;
					mrs_addr[`WL_BIT_RTT2] = r.rtt[2];
					mrs_addr[`WL_BIT_RTT1] = r.rtt[1];
					mrs_addr[`WL_BIT_RTT0] = r.rtt[0];
					n.timer = 10'(`WL_MODE_UPDATE_CYC);
					n.state = wl_pkg::CS_WAIT_END;
				end
			end
			wl_pkg::CS_WAIT_END: begin
				if (r.timer == 10'h0) begin
					n.busy  = 1'b0;
					n.done  = ~r.err;
					n.state = wl_pkg::CS_IDLE;
				end
			end
			default: n.state = wl_pkg::CS_IDLE;
		endcase

		// Strobe pulse window per lane, relative to the clock fall
		if (n.state == wl_pkg::CS_PULSE) begin
			for (int l = 0; l < `WL_LANES; l++) begin
				n.dqs[l] = ({1'b0, n.tap[l]} <= n.pcnt) &&
					(n.pcnt < ({1'b0, n.tap[l]} +
					4'(`WL_DQS_HIGH_CYC)));
			end
		end else begin
			n.dqs = '0;
		end

		// Only mode writes are issued; otherwise deselect
		if (mrs_go) begin
			n.cs_n           = 2'h3;
			n.cs_n[mrs_rank] = 1'b0;
			n.ras_n          = 1'b0;
			n.cas_n          = 1'b0;
			n.we_n           = 1'b0;
			n.ba             = `WL_MR1_BA;
			n.addr           = mrs_addr;
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			r       <= '0;
			r.cs_n  <= 2'h3;
			r.ras_n <= 1'b1;
			r.cas_n <= 1'b1;
			r.we_n  <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign waitrequest   = req & ~r.ack;
	assign readdata      = r.rdata;
	// The bus the device drives is terminated here while busy
	assign dq_term_on    = r.busy;
	assign wl.ck_t       = r.ck;
	assign wl.ck_c       = ~r.ck;
	assign wl.cs_n       = r.cs_n;
	assign wl.ras_n      = r.ras_n;
	assign wl.cas_n      = r.cas_n;
	assign wl.we_n       = r.we_n;
	assign wl.ba         = r.ba;
	assign wl.addr       = r.addr;
	assign wl.odt        = r.odt;
	assign wl.ctl_dqs_o  = r.dqs;
	assign wl.ctl_dqs_oe = r.dqs_oe;
	assign wl.ctl_dq_o   = '0;
	assign wl.ctl_dq_oe  = '0;
endmodule // wl_ctrl

// *** tb/wl_checker.sv ***
`timescale 1ns/1ps
`include "wl_defines.svh"

module wl_checker (
	input wire logic                  mclk,
	input wire logic                  reset_n,
	input wire logic                  ck_t,
	input wire logic [1:0]            cs_n,
	input wire logic                  ras_n,
	input wire logic                  cas_n,
	input wire logic                  we_n,
	input wire logic [2:0]            ba,
	input wire logic [`WL_ADDR_W-1:0] addr,
	input wire logic                  odt,
	input wire logic [`WL_LANES-1:0]  ctl_dqs_oe,
	input wire logic [`WL_LANES-1:0]  dqs_t,
	input wire logic [`WL_DQ_W-1:0]   dq,
	input wire logic [`WL_LANES-1:0]  dev_dqs_oe,
	input wire logic [`WL_DQ_W-1:0]   dev_dq_oe
);
	logic       cmd;
	logic       cmd_start;
	logic       idle_reg;
	logic [9:0] gap_reg;

	// ------------------------------
	// Cycles since the last command
	// ------------------------------
	assign cmd = cs_n != 2'h3;
	assign cmd_start = cmd && idle_reg;
	// Saturates so a long idle never wraps into a false short gap
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			idle_reg <= 1'b1;
			gap_reg <= 10'h3ff;
		end else begin
			idle_reg <= !cmd;
			if (cmd_start)
				gap_reg <= 10'h0;
			else if (gap_reg != 10'h3ff)
				gap_reg <= gap_reg + 10'h1;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	sequence exit_cmd;
		$fell(cs_n[0]) && !addr[7] && !addr[12];
	endsequence
	sequence strobe_high;
		dqs_t[0] [*4] ##1 !dqs_t[0];
	endsequence

	a_only_mode_cmds: assert property (cmd |-> !ras_n && !cas_n &&
		!we_n && ba == 3'h1) else $error("command other than mode write");
	a_mode_spacing: assert property (cmd_start |-> gap_reg >= 10'd31)
		else $error("mode writes too close");
	a_odt_after_mod: assert property ($rose(odt) |-> gap_reg >= 10'd95)
		else $error("odt raised too soon");
	a_strobe_low_first: assert property ($rose(|ctl_dqs_oe) |->
		odt && dqs_t == 2'h0) else $error("strobe not driven low first");
	a_single_edge: assert property ($rose(dqs_t[0]) |-> strobe_high)
		else $error("strobe pulse malformed");
	a_fb_low_lane: assert property ($rose(dqs_t[0]) && dev_dq_oe[0]
		|-> ##6 dq[7:0] == {8{$past(ck_t, 6)}})
		else $error("low lane feedback wrong");
	a_fb_high_lane: assert property ($rose(dqs_t[1]) && dev_dq_oe[8]
		|-> ##6 dq[15:8] == {8{$past(ck_t, 6)}})
		else $error("high lane feedback wrong");
	a_no_read_strobe: assert property (dev_dqs_oe == 2'h0)
		else $error("device drove a strobe");
	a_strobe_before_odt: assert property ($fell(odt) |->
		ctl_dqs_oe == 2'h0) else $error("odt dropped while strobing");
	a_exit_after_odt: assert property (exit_cmd |-> !odt)
		else $error("exit write with odt high");
	a_enter_drives: assert property ($fell(cs_n[0]) && addr[7] &&
		!addr[12] |-> ##[1:16] dev_dq_oe == 16'hffff)
		else $error("device did not enter leveling");
	a_exit_release: assert property (exit_cmd |-> ##90
		dev_dq_oe != 16'h0 ##[1:30] dev_dq_oe == 16'h0)
		else $error("device exit timing wrong");
endmodule // wl_checker

// *** tb/dram_write_leveling_bench.sv ***
`timescale 1ns/1ps
`include "wl_defines.svh"

module dram_write_leveling_bench;
	logic        mclk = 1'b0;
	logic        reset_n = 1'b0;
	logic [3:0]  address = 4'h0;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        ctl_dqt_on;
	logic        lvl_act;
	logic        dq_undef;
	logic        dqs_on;
	logic        dev_dqt_on;
	logic [31:0] q;
	int          mismatches = 0;
	int          total_checks = 0;

	wl_if wl ();
	always #5 mclk = ~mclk;

	wl_ctrl wl_ctrl_i (.mclk(mclk), .reset_n(reset_n), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest),
		.dq_term_on(ctl_dqt_on), .wl(wl.ctl));
	wl_dram #(.RANK(1'b0)) wl_dram_i (.mclk(mclk), .reset_n(reset_n),
		.wl(wl.dev), .leveling_active(lvl_act), .dq_undefined(dq_undef),
		.dqs_term_on(dqs_on), .dq_term_on(dev_dqt_on));
	wl_checker wl_checker_i (.mclk(mclk), .reset_n(reset_n),
		.ck_t(wl.ck_t), .cs_n(wl.cs_n), .ras_n(wl.ras_n),
		.cas_n(wl.cas_n), .we_n(wl.we_n), .ba(wl.ba), .addr(wl.addr),
		.odt(wl.odt), .ctl_dqs_oe(wl.ctl_dqs_oe), .dqs_t(wl.dqs_t),
		.dq(wl.dq), .dev_dqs_oe(wl.dev_dqs_oe), .dev_dq_oe(wl.dev_dq_oe));

	// ------------------------------
	// Shared tasks
	// ------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [3:0] a,
		input logic [31:0] d);
		@(posedge mclk);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= !wr;
		// Wait state seen mid-cycle so the closing edge is known
		@(negedge mclk);
		while (waitrequest !== 1'b0) @(negedge mclk);
		@(posedge mclk);
		q = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask

	task automatic complete_run();
		$display("mismatches=%0d total_checks=%0d", mismatches, total_checks);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ------------------------------
	// Scenarios
	// ------------------------------
	task automatic t_idle();
		check({lvl_act, wl.cs_n, wl.odt}, 32'h6);
		bus(1'b1, 4'hc, 32'h1);
		bus(1'b0, 4'hc, 32'h0);
		check(q, 32'h0);
		bus(1'b0, `WL_REG_STATUS, 32'h0);
		check(q, 32'h0);
	endtask

	// Illegal termination codes must be refused before any command
	task automatic t_bad_rtt();
		for (int i = 0; i < 8; i++) begin
			if (i > 0 && i < 4)
				continue;
			bus(1'b1, `WL_REG_CTRL, {28'h0, i[2:0], 1'b1});
			bus(1'b0, `WL_REG_STATUS, 32'h0);
			check(q, 32'h4);
		end
		check(lvl_act, 1'b0);
	endtask

	task automatic t_mid_reset();
		bus(1'b1, `WL_REG_CTRL, 32'h3);
		repeat (300) @(posedge mclk);
		check(lvl_act, 1'b1);
		reset_n <= 1'b0;
		repeat (16) @(posedge mclk);
		check({lvl_act, wl.odt, wl.cs_n}, 32'h3);
		reset_n <= 1'b1;
		bus(1'b0, `WL_REG_STATUS, 32'h0);
		check(q, 32'h0);
	endtask

	// Second write lands while busy and must be ignored
	task automatic t_level(input logic [2:0] rtt, input logic rank);
		int n;
		n = 0;
		bus(1'b1, `WL_REG_CTRL, {27'h0, rank, rtt, 1'b1});
		bus(1'b1, `WL_REG_CTRL, 32'h1);
		do begin
			@(posedge mclk);
			#1;
			n++;
			if (!rank && |wl.ctl_dqs_oe)
				check({dqs_on, dev_dqt_on, ctl_dqt_on}, 32'h5);
			if (!rank && wl.odt && !wl.ctl_dqs_oe[0])
				check(dq_undef, 1'b1);
			if (wl.cs_n[!rank] === 1'b0)
				check(wl.addr[12], 1'b1);
			if (wl.cs_n[rank] === 1'b0 && wl.addr[7])
				check({wl.addr[9], wl.addr[6], wl.addr[2]}, rtt);
		end while (ctl_dqt_on || n < 8);
		bus(1'b0, `WL_REG_STATUS, 32'h0);
		check(q, rank ? 32'h4 : 32'h1a);
		if (!rank) begin
			bus(1'b0, `WL_REG_DELAY, 32'h0);
			check(q, 32'h404);
			n = 0;
			while (lvl_act && n < 64) begin
				@(posedge mclk);
				n++;
			end
			check(lvl_act, 1'b0);
		end
	endtask

	// ------------------------------
	// Main sequence and watchdog
	// ------------------------------
	initial begin
		repeat (16) @(posedge mclk);
		reset_n <= 1'b1;
		t_idle();
		t_bad_rtt();
		t_mid_reset();
		for (int r = 1; r < 4; r++)
			t_level(r[2:0], 1'b0);
		// Last: no device answers this rank, so leveling must fail
		t_level(3'h2, 1'b1);
		complete_run();
	end

	initial begin
		repeat (40000) @(posedge mclk);
		mismatches++;
		complete_run();
	end
endmodule // dram_write_leveling_bench
